// >>> hdl/ibcs_top.v
// Interrupt entry, bank selection, trap ordering and context switch
`timescale 1ns/1ns
`include "ibcs_map.vh"
module ibcs_top (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Interrupt request
  input wire irqReq,
  input wire [3:0] irqLevel,
  input wire [1:0] irqBankSelectCode,
  output reg irqAck,
  // Peripheral event transfer and debug service
  input wire pecReq,
  output reg pecAck,
  input wire dbgReq,
  input wire [4:0] dbgLevel,
  output reg dbgAck,
  input wire dbgBreak,
  // Traps
  input wire trapAReq,
  input wire trapBReq,
  output reg trapAAck,
  output reg trapBAck,
  output reg trapBInject,
  input wire trapBAtExecute,
  // Pipeline events
  input wire cpWrite,
  input wire idleExec,
  input wire retiExec,
  input wire [15:0] stackPswIn,
  input wire pswWrite,
  input wire [15:0] pswWriteData,
  input wire mulDivMispredict,
  input wire consecWrite,
  input wire waitedWrite,
  input wire [23:0] stackAddr,
  // Control register two
  input wire con2Write,
  input wire [15:0] con2WriteData,
  output reg [15:0] cpuControlTwo,
  // Status and pipeline control
  output reg [15:0] processorStatusWord,
  output reg pipeCancel,
  output reg pipeStall,
  output reg ctxBusy,
  output reg ctxLoad,
  output reg stackInDpram
);
  wire cswBusy;
  wire cswStore;
  wire cswLoad;
  wire cswDone;
  wire cswStart;
  reg trapBPendQ;
  reg trapBDeferQ;
  reg trapBInjQ;
  wire [1:0] curBank;
  wire [3:0] curLevel;
  wire [1:0] entryBank;
  wire irqWins;
  wire bubbleOverrun;

  assign curBank = processorStatusWord[`IBCS_BANK_LSB+1:`IBCS_BANK_LSB];
  assign curLevel = processorStatusWord[`IBCS_LEVEL_LSB+3:`IBCS_LEVEL_LSB];
  assign bubbleOverrun = cpuControlTwo[`IBCS_BUBBLE_OVERRUN_ENABLE_BIT];
  assign cswStart = cpWrite | idleExec;
  // Bank choice on entry; below level 12 the current bank is kept
  assign entryBank = (irqLevel >= `IBCS_AUTO_LEVEL) ?
    (irqBankSelectCode[1] ? {1'b1, irqBankSelectCode[0]} :
    `IBCS_BANK_GLOBAL) : curBank;
  // Priority alone decides; bank and switch state never hold service
  assign irqWins = irqReq && (irqLevel > curLevel);

  ibcs_ctx_switch uCsw (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(cswStart),
    .busy(cswBusy),
    .storePhase(cswStore),
    .loadPhase(cswLoad),
    .done(cswDone)
  );

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      processorStatusWord <= `IBCS_PSW_RESET;
      cpuControlTwo <= `IBCS_CON2_RESET;
      irqAck <= 1'b0;
      pecAck <= 1'b0;
      dbgAck <= 1'b0;
      trapAAck <= 1'b0;
      trapBAck <= 1'b0;
      trapBInject <= 1'b0;
      trapBPendQ <= 1'b0;
      trapBDeferQ <= 1'b0;
      trapBInjQ <= 1'b0;
      pipeCancel <= 1'b0;
      pipeStall <= 1'b0;
      ctxBusy <= 1'b0;
      ctxLoad <= 1'b0;
      stackInDpram <= 1'b0;
    end else begin
      irqAck <= 1'b0;
      pecAck <= 1'b0;
      dbgAck <= 1'b0;
      trapAAck <= 1'b0;
      trapBAck <= 1'b0;
      trapBInject <= 1'b0;
      ctxBusy <= cswBusy;
      ctxLoad <= cswLoad;
      stackInDpram <= (stackAddr >= `IBCS_DUAL_PORTED_RAM_LO) &&
        (stackAddr <= `IBCS_DUAL_PORTED_RAM_HI);
      if (con2Write)
        cpuControlTwo <= con2WriteData;
      // Stall only for write traffic, never for a trap in a switch
      pipeStall <= consecWrite | (waitedWrite & ~bubbleOverrun);
      pipeCancel <= mulDivMispredict | dbgBreak |
        (trapAReq & trapBInjQ & ~trapBAtExecute);
      // Trap B inject, then wait for it at execute
      if (trapBPendQ && !trapBInjQ && !trapBDeferQ) begin
        trapBInject <= 1'b1;
        trapBInjQ <= 1'b1;
      end
      // Traps are honoured in any switch phase, load included
      if (trapAReq) begin
        trapAAck <= 1'b1;
        if (trapBInjQ && !trapBAtExecute) begin
          trapBDeferQ <= 1'b1;
          trapBInjQ <= 1'b0;
        end
      end else if (trapBInjQ && trapBAtExecute) begin
        trapBAck <= 1'b1;
        trapBInjQ <= 1'b0;
        trapBPendQ <= 1'b0;
      end else if (retiExec && trapBDeferQ) begin
        trapBAck <= 1'b1;
        trapBDeferQ <= 1'b0;
        trapBPendQ <= 1'b0;
      end
      // New request beats a clear in the same cycle
      if (trapBReq)
        trapBPendQ <= 1'b1;
      // Other requests served now, not held to a later return
      if (pecReq)
        pecAck <= 1'b1;
      if (dbgReq && dbgLevel < `IBCS_DEBUG_LEVEL)
        dbgAck <= 1'b1;
      // Status word: return beats write beats entry
      if (retiExec)
        processorStatusWord <= stackPswIn;
      else if (pswWrite)
        processorStatusWord <= pswWriteData;
      else if (irqWins && !trapAReq) begin
        irqAck <= 1'b1;
        processorStatusWord[`IBCS_BANK_LSB+1:`IBCS_BANK_LSB] <=
          entryBank;
        processorStatusWord[`IBCS_LEVEL_LSB+3:`IBCS_LEVEL_LSB] <= irqLevel;
      end
    end
  end
endmodule // ibcs_top

// >>> hdl/ibcs_map.vh
// Constants for the interrupt bank and context switch controller
// Notes on behaviour
// - Status word bank field: 00 global, 10 or 11 a local bank.
// - Level 12 and above takes its bank from the bank select code.
// - Writing the context base pointer starts a 19 cycle context switch.
// - Switch runs store then load; a trap in load is still entered.
// - Idle instruction starts the same store then load context switch.
// - Global bank interrupt preempts a local bank routine by priority only.
// - Return from interrupt restores status word and bank from the stack.
// - Trap in a local bank routine during a switch never stalls the CPU.
// - Class A before pending class B injection: A first, B at next return.
// - Cancel pipeline on mul/div mispredict or debug break; traps still enter.
// - Later requests are never postponed to a later return after a trap.
// - Bubble overrun enable is bit 4 of control register two; 0 disables.
// - Pipeline stalls on consecutive writes, or on waited multi-cycle writes when bubble overrun is disabled.
// - Switches and trap entry work with the stack in dual ported RAM.
`ifndef IBCS_MAP_VH
`define IBCS_MAP_VH
`define IBCS_BANK_GLOBAL 2'h0
`define IBCS_BANK_LOCAL0 2'h2
`define IBCS_BANK_LOCAL1 2'h3
`define IBCS_AUTO_LEVEL 4'hc
`define IBCS_DEBUG_LEVEL 5'h11
`define IBCS_CSW_CYCLES 5'h13
`define IBCS_CSW_STORE 5'h0a
`define IBCS_BUBBLE_OVERRUN_ENABLE_BIT 4
`define IBCS_CON2_RESET 16'h0010
`define IBCS_DUAL_PORTED_RAM_LO 24'h00f600
`define IBCS_DUAL_PORTED_RAM_HI 24'h00fdff
`define IBCS_PSW_RESET 16'h0000
`define IBCS_BANK_LSB 8
`define IBCS_LEVEL_LSB 12
`endif

// >>> hdl/ibcs_ctx_switch.v
// Context switch sequencer: store half then load half
`timescale 1ns/1ns
`include "ibcs_map.vh"
module ibcs_ctx_switch (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Start and status
  input wire start,
  output reg busy,
  output reg storePhase,
  output reg loadPhase,
  output reg done
);
  reg [4:0] countQ;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      countQ <= 5'h00;
      busy <= 1'b0;
      storePhase <= 1'b0;
      loadPhase <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        storePhase <= 1'b1;
        countQ <= 5'h01;
      end else if (busy) begin
        if (countQ == `IBCS_CSW_CYCLES) begin
          busy <= 1'b0;
          loadPhase <= 1'b0;
          done <= 1'b1;
          countQ <= 5'h00;
        end else begin
          countQ <= countQ + 5'h01;
          if (countQ == `IBCS_CSW_STORE) begin
            storePhase <= 1'b0;
            loadPhase <= 1'b1;
          end
        end
      end
    end
  end
endmodule // ibcs_ctx_switch

// >>> bench/ibcs_asserts.sv
// Port-level checks on the controller top
`timescale 1ns/1ns
module ibcs_asserts (
  // Inputs and outputs watched
  input logic core_clk, reset_n, irqReq, irqAck, pecReq, pecAck,
  input logic dbgAck, dbgBreak, trapAReq, trapAAck, cpWrite, idleExec,
  input logic retiExec, mulDivMispredict, waitedWrite, pipeCancel,
  input logic pipeStall, ctxBusy, ctxLoad, stackInDpram, consecWrite,
  input logic [4:0] dbgLevel,
  input logic [15:0] stackPswIn, cpuControlTwo, processorStatusWord,
  input logic [23:0] stackAddr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_bank_legal: assert property (
    processorStatusWord[9:8] != 2'h1) else $error("bad bank");
  a_ctx_len: assert property (
    $rose(ctxBusy) |-> ##18 ctxBusy ##1 !ctxBusy)
    else $error("switch length");
  a_ctx_cause: assert property ($rose(ctxBusy) |->
    $past(cpWrite, 2) || $past(idleExec, 2)) else $error("switch cause");
  a_store_first: assert property ($rose(ctxBusy) |-> !ctxLoad[*8])
    else $error("load early");
  a_load_last: assert property ($fell(ctxBusy) |-> $past(ctxLoad))
    else $error("load late");
  a_return_from_interrupt_psw: assert property (retiExec |=>
    processorStatusWord == $past(stackPswIn)) else $error("psw restore");
  a_irq_cause: assert property (irqAck |-> $past(irqReq))
    else $error("irq ack");
  a_dbg_level: assert property (dbgAck |-> $past(dbgLevel) < 5'h11)
    else $error("dbg level");
  a_pec_ack: assert property (pecReq |=> pecAck)
    else $error("pec ack");
  a_trap_a: assert property (trapAReq |=> trapAAck)
    else $error("trap lost");
  a_cancel_pipe: assert property (
    dbgBreak || mulDivMispredict |=> pipeCancel) else $error("no cancel");
  a_stall_cause: assert property (
    waitedWrite && !cpuControlTwo[4] |=> pipeStall) else $error("no stall");
  a_no_trap_stall: assert property (pipeStall |->
    $past(consecWrite) || $past(waitedWrite)) else $error("trap stall");
  a_dual_ported_ram_flag: assert property (stackAddr >= 24'h00f600 &&
    stackAddr <= 24'h00fdff |=> stackInDpram) else $error("dual_ported_ram");
endmodule // ibcs_asserts
bind ibcs_top ibcs_asserts u_chk (.*);

// >>> bench/ibcs_pipe_model.sv
// Pipeline model: injected class B trap reaches execute later
`timescale 1ns/1ns
module ibcs_pipe_model #(parameter LAT = 3) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Injection handshake
  input wire trapBInject,
  output reg trapBAtExecute
);
  reg [3:0] age_q;
  // Slow on purpose so a class A trap can overtake
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      age_q <= 4'h0;
      trapBAtExecute <= 1'h0;
    end else begin
      age_q <= trapBInject ? 4'(LAT) : age_q - 4'(age_q != 4'h0);
      trapBAtExecute <= age_q == 4'h1;
    end
  end
endmodule // ibcs_pipe_model

// >>> bench/testbench.sv
// Self-checking bench for the controller top
`timescale 1ns/1ns
module testbench;
  logic core_clk = 0, reset_n = 0, irqReq = 0, pecReq = 0, dbgReq = 0;
  logic dbgBreak = 0, trapAReq = 0, trapBReq = 0, cpWrite = 0, idleExec = 0;
  logic retiExec = 0, pswWrite = 0, mulDivMispredict = 0, consecWrite = 0;
  logic waitedWrite = 0, con2Write = 0, irqAck, pecAck, dbgAck, trapAAck;
  logic trapBAck, trapBInject, trapBAtExecute, pipeCancel, pipeStall;
  logic ctxBusy, ctxLoad, stackInDpram;
  logic [3:0] irqLevel = 0;
  logic [1:0] irqBankSelectCode = 0;
  logic [4:0] dbgLevel = 0;
  logic [15:0] stackPswIn = 0, pswWriteData = 0, con2WriteData = 0;
  logic [15:0] cpuControlTwo, processorStatusWord;
  logic [23:0] stackAddr = 0;
  int failures = 0, checks_done = 0, n;
  // Stack address, restored status word, expected dual_ported_ram flag
  logic [40:0] rows [4] = '{{24'h00f5ff, 16'h0200, 1'h0},
    {24'h00f600, 16'h0300, 1'h1}, {24'h00fdff, 16'h0000, 1'h1},
    {24'h00fe00, 16'h0000, 1'h0}};
  ibcs_top u_dut (.*);
  ibcs_pipe_model #(.LAT(3)) u_pipe (.*);
  initial forever #50 core_clk = ~core_clk;
  task chk(input logic [23:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tick;
    @(posedge core_clk);
  endtask
  // Counts high cycles from the current edge on
  task automatic cnt(ref logic s, input int w);
    n = 0;
    repeat (w) begin
      #1 n += s;
      tick;
    end
  endtask
  initial begin
    repeat (4) tick;
    chk(cpuControlTwo, 16'h0010);
    chk(processorStatusWord, 16'h0000);
    reset_n <= 1;
    foreach (rows[i]) begin
      tick;
      {stackAddr, stackPswIn} <= rows[i][40:1];
      retiExec <= 1;
      tick;
      retiExec <= 0;
      #1 chk(processorStatusWord, rows[i][16:1]);
      chk(stackInDpram, rows[i][0]);
    end
    for (int k = 0; k < 2; k++) begin
      tick;
      cpWrite <= k == 0;
      idleExec <= k == 1;
      tick;
      cpWrite <= 0;
      idleExec <= 0;
      cnt(ctxBusy, 30);
      chk(n, 19);
    end
    irqLevel <= 4'hd;
    irqBankSelectCode <= 2'h2;
    irqReq <= 1;
    tick;
    irqReq <= 0;
    cnt(irqAck, 4);
    chk(n, 1);
    chk(processorStatusWord, 16'hd200);
    for (int k = 0; k < 2; k++) begin
      dbgLevel <= 5'h10 + 5'(k);
      dbgReq <= 1;
      pecReq <= 1;
      dbgBreak <= k == 0;
      mulDivMispredict <= k == 1;
      tick;
      dbgReq <= 0;
      pecReq <= 0;
      dbgBreak <= 0;
      mulDivMispredict <= 0;
      cnt(dbgAck, 3);
      chk(n, k == 0);
    end
    con2Write <= 1;
    tick;
    con2Write <= 0;
    waitedWrite <= 1;
    tick;
    waitedWrite <= 0;
    #1 chk(cpuControlTwo, 16'h0000);
    chk(pipeStall, 1);
    // Class A overtakes a class B injected but not yet at execute
    trapBReq <= 1;
    tick;
    trapBReq <= 0;
    tick;
    trapAReq <= 1;
    tick;
    trapAReq <= 0;
    #1 chk(trapAAck, 1);
    cnt(trapBAck, 8);
    chk(n, 0);
    retiExec <= 1;
    tick;
    retiExec <= 0;
    cnt(trapBAck, 8);
    chk(n, 1);
    // Mid-run reset brings the control register back
    reset_n <= 0;
    tick;
    #1 chk(cpuControlTwo, 16'h0010);
    reset_n <= 1;
    tick;
    report_and_stop;
  end
endmodule // testbench
